// file: rtl/dgch_pkg.sv
package dgch_pkg;
  // clock and tick
  localparam int unsigned MCLK_HZ = 20_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (MCLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_MS = 1;
  // protocol times in ms, then in ticks
  localparam int unsigned ANSWER_WAIT_MS = 4;
  localparam int unsigned FADE_UNIT_MS = 10;
  localparam int unsigned BLOCK_MS = 19;
  localparam int unsigned CFG_WINDOW_MS = 100;
  localparam int unsigned DAPC_SEQ_MS = 200;
  localparam int unsigned IF_FAIL_MS = 500;
  localparam int unsigned TMR_W = 10;
  typedef logic [TMR_W-1:0] dgch_tmr_t;
  localparam dgch_tmr_t ANSWER_WAIT_TICKS = dgch_tmr_t'(ANSWER_WAIT_MS / TICK_MS);
  localparam logic [3:0] FADE_UNIT_TICKS = 4'(FADE_UNIT_MS / TICK_MS);
  localparam dgch_tmr_t BLOCK_TICKS = dgch_tmr_t'(BLOCK_MS / TICK_MS);
  localparam dgch_tmr_t CFG_WINDOW_TICKS = dgch_tmr_t'(CFG_WINDOW_MS / TICK_MS);
  localparam dgch_tmr_t DAPC_SEQ_TICKS = dgch_tmr_t'(DAPC_SEQ_MS / TICK_MS);
  localparam dgch_tmr_t IF_FAIL_TICKS = dgch_tmr_t'(IF_FAIL_MS / TICK_MS);
  // register byte offsets
  localparam logic [3:0] REG_ADDR = 4'h0;
  localparam logic [3:0] REG_LEVEL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_FRAME = 4'hc;
  localparam int unsigned STS_CLR_FAIL_BIT = 8;
  // reset values
  localparam logic [5:0] RST_SHORT_ADDR = 6'h3f;
  localparam logic [15:0] RST_GROUP_MASK = 16'h0000;
  localparam logic [7:0] RST_MIN_LEVEL = 8'h01;
  localparam logic [7:0] RST_MAX_LEVEL = 8'hfe;
  localparam logic [7:0] RST_FADE_COUNT = 8'h00;
  // status information byte
  localparam int unsigned STS_FAIL_BIT = 0;
  localparam int unsigned STS_LAMP_ON_BIT = 2;
  localparam int unsigned STS_FADE_BIT = 4;
  // command codes and ranges
  localparam logic [7:0] CMD_MASK_LEVEL = 8'hff;
  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] CMD_STEP_UP = 8'h03;
  localparam logic [7:0] CMD_STEP_DOWN = 8'h04;
  localparam logic [7:0] CMD_RECALL_MAX = 8'h05;
  localparam logic [7:0] CMD_RECALL_MIN = 8'h06;
  localparam logic [7:0] CMD_ENABLE_DAPC = 8'h09;
  localparam logic [7:0] CMD_CFG_FIRST = 8'h20;
  localparam logic [7:0] CMD_CFG_LAST = 8'h81;
  localparam logic [7:0] CMD_QRY_FIRST = 8'h90;
  localparam logic [7:0] CMD_QRY_LAST = 8'hc4;
  localparam logic [7:0] CMD_QRY_STATUS = 8'h90;
  localparam logic [7:0] CMD_QRY_ACTUAL = 8'ha0;
  localparam logic [7:0] CMD_QRY_MAX = 8'ha1;
  localparam logic [7:0] CMD_QRY_MIN = 8'ha2;

  typedef struct packed {
    logic done;
    logic error;
    logic [15:0] frame;
  } dgch_rx_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } dgch_byte_s;

  typedef struct packed {
    logic valid;
    logic [15:0] frame;
  } dgch_frame_s;

  typedef struct packed {
    logic done;
    logic fail;
  } dgch_nvm_s;
endpackage

// file: rtl/dgch_command_handler.sv
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
module dgch_command_handler
  import dgch_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire dgch_rx_s rxIn,
  output logic rxFlagClear,
  input wire logic busLine,
  input wire logic randomAddrBusy,
  input wire dgch_nvm_s nvmIn,
  output logic nvmSaveReq,
  output dgch_byte_s answerOut,
  output dgch_frame_s cfgExecOut,
  output dgch_frame_s specialOut,
  output logic [7:0] actualLevel,
  output logic [7:0] statusInfo
);

  function automatic dgch_tmr_t tmr_dec(input dgch_tmr_t t, input logic tick);
    tmr_dec = (tick && t != '0) ? t - dgch_tmr_t'(1) : t;
  endfunction

  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++)
    begin
      be_merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  logic [15:0] tickCnt_q;
  logic tick_q;
  logic busMeta_q, busSync_q;
  logic [5:0] shortAddr_q;
  logic [15:0] groupMask_q;
  logic [7:0] minLevel_q, maxLevel_q, fadeCount_q;
  logic [7:0] actual_q, target_q, prevActual_q;
  logic fadeRun_q;
  logic [7:0] fadeLeft_q;
  logic [3:0] tenMsIntervalCnt_q;
  logic answerPend_q;
  dgch_tmr_t answerWait_q, blockTmr_q, cfgWin_q, dapcSeq_q, ifFailCnt_q;
  logic [7:0] answerData_q;
  logic [15:0] cfgPrev_q, lastFrame_q;
  logic sysFail_q, saveBusy_q, savePend_q;
  logic [7:0] adrByte, cmdByte, dapcLevel;
  logic poll, frameOk, isShort, isGroup, isBcast, isSpecial, selected;
  logic isDapc, isArc, isCfg, isQuery, cfgRun, ifFailEvt, saveFailEvt, saveStart, failClr;
  logic hasAnswer;
  logic [7:0] answerByte;
  logic [7:0] statusByte;
  logic [31:0] addrMerge, levelMerge;

  // protocol tick, shortened in simulation through the parameter
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      tickCnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (tickCnt_q == 16'(TICK_CYCLES_P - 1));
      tickCnt_q <= (tickCnt_q == 16'(TICK_CYCLES_P - 1)) ? 16'h0000 : tickCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      busMeta_q <= 1'b1;
      busSync_q <= 1'b1;
    end
    else
    begin
      busMeta_q <= busLine;
      busSync_q <= busMeta_q;
    end
  end

  always_comb
  begin
    adrByte = rxIn.frame[15:8];
    cmdByte = rxIn.frame[7:0];
    poll = rxIn.done && !rxFlagClear;
    frameOk = poll && !rxIn.error && blockTmr_q == '0;
    isShort = !adrByte[7];
    isGroup = adrByte[7:5] == 3'b100;
    isBcast = adrByte[7:1] == 7'h7f;
    isSpecial = frameOk && !(isShort || isGroup || isBcast);
    selected = frameOk && ((isShort && adrByte[6:1] == shortAddr_q) ||
               (isGroup && groupMask_q[adrByte[4:1]]) || isBcast);
    isDapc = selected && !adrByte[0];
    isArc = selected && adrByte[0] && cmdByte < CMD_CFG_FIRST;
    isCfg = selected && adrByte[0] && cmdByte >= CMD_CFG_FIRST && cmdByte <= CMD_CFG_LAST;
    isQuery = selected && adrByte[0] && cmdByte >= CMD_QRY_FIRST && cmdByte <= CMD_QRY_LAST;
    cfgRun = isCfg && cfgWin_q != '0 && cfgPrev_q == rxIn.frame;
    dapcLevel = clamp(cmdByte, minLevel_q, maxLevel_q);
    ifFailEvt = !busSync_q && tick_q && ifFailCnt_q == IF_FAIL_TICKS - dgch_tmr_t'(1);
    saveFailEvt = saveBusy_q && nvmIn.fail;
    saveStart = savePend_q && !answerPend_q && !randomAddrBusy && !saveBusy_q;
    failClr = avs_write && !avs_waitrequest && avs_address == REG_STATUS &&
              avs_byteenable[1] && avs_writedata[STS_CLR_FAIL_BIT];
    addrMerge = be_merge({groupMask_q, 10'h000, shortAddr_q}, avs_writedata, avs_byteenable);
    levelMerge = be_merge({8'h00, fadeCount_q, maxLevel_q, minLevel_q}, avs_writedata, avs_byteenable);
    statusByte = 8'h00;
    statusByte[STS_FAIL_BIT] = sysFail_q;
    statusByte[STS_LAMP_ON_BIT] = actual_q != 8'h00;
    statusByte[STS_FADE_BIT] = fadeRun_q;
    hasAnswer = 1'b1;
    case (cmdByte)
      CMD_QRY_STATUS: answerByte = statusByte;
      CMD_QRY_ACTUAL: answerByte = actual_q;
      CMD_QRY_MAX: answerByte = maxLevel_q;
      CMD_QRY_MIN: answerByte = minLevel_q;
      default:
      begin
        answerByte = 8'h00;
        hasAnswer = 1'b0;
      end
    endcase
  end

  // flags are cleared once per poll so a frame is never taken twice
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      rxFlagClear <= 1'b0;
      lastFrame_q <= 16'h0000;
      specialOut <= '0;
    end
    else
    begin
      rxFlagClear <= poll;
      if (frameOk)
        lastFrame_q <= rxIn.frame;
      specialOut.valid <= isSpecial;
      if (isSpecial)
        specialOut.frame <= rxIn.frame;
    end
  end

  // levels and fade
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      actual_q <= 8'h00;
      target_q <= 8'h00;
      fadeRun_q <= 1'b0;
      fadeLeft_q <= 8'h00;
      tenMsIntervalCnt_q <= 4'h0;
    end
    else
    begin
      if (tick_q)
        tenMsIntervalCnt_q <= (tenMsIntervalCnt_q == FADE_UNIT_TICKS - 4'h1) ? 4'h0 : tenMsIntervalCnt_q + 4'h1;
      if (isDapc && cmdByte != CMD_MASK_LEVEL)
      begin
        target_q <= dapcLevel;
        if (fadeCount_q == 8'h00 || actual_q == 8'h00)
        begin
          actual_q <= dapcLevel;
          fadeRun_q <= 1'b0;
        end
        else
        begin
          fadeRun_q <= 1'b1;
          fadeLeft_q <= fadeCount_q;
          tenMsIntervalCnt_q <= 4'h0;
        end
      end
      else if (isArc)
      begin
        fadeRun_q <= 1'b0;
        case (cmdByte)
          CMD_OFF:
          begin
            actual_q <= 8'h00;
            target_q <= 8'h00;
          end
          CMD_STEP_UP:
            if (actual_q != 8'h00 && actual_q < maxLevel_q)
              actual_q <= actual_q + 8'h01;
          CMD_STEP_DOWN:
            if (actual_q != 8'h00 && actual_q > minLevel_q)
              actual_q <= actual_q - 8'h01;
          CMD_RECALL_MAX:
            if (actual_q != 8'h00)
              actual_q <= maxLevel_q;
          CMD_RECALL_MIN:
            if (actual_q != 8'h00)
              actual_q <= minLevel_q;
          default:
            fadeRun_q <= fadeRun_q;
        endcase
      end
      else if (sysFail_q)
        fadeRun_q <= 1'b0;
      else if (fadeRun_q && tick_q && tenMsIntervalCnt_q == FADE_UNIT_TICKS - 4'h1)
      begin
        if (fadeLeft_q <= 8'h01)
        begin
          actual_q <= target_q;
          fadeRun_q <= 1'b0;
        end
        else
          fadeLeft_q <= fadeLeft_q - 8'h01;
      end
    end
  end

  // backward frame timing and reception blocking
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      answerPend_q <= 1'b0;
      answerWait_q <= '0;
      answerData_q <= 8'h00;
      blockTmr_q <= '0;
      answerOut <= '0;
    end
    else
    begin
      answerOut.valid <= 1'b0;
      if (isQuery && hasAnswer)
      begin
        answerPend_q <= 1'b1;
        answerWait_q <= ANSWER_WAIT_TICKS;
        answerData_q <= answerByte;
      end
      else if (answerPend_q && answerWait_q == '0)
      begin
        answerPend_q <= 1'b0;
        answerOut.valid <= 1'b1;
        answerOut.data <= answerData_q;
      end
      else
        answerWait_q <= tmr_dec(answerWait_q, tick_q);
      if (isQuery)
        blockTmr_q <= BLOCK_TICKS;
      else
        blockTmr_q <= tmr_dec(blockTmr_q, tick_q);
    end
  end

  // repeated configuration, direct level sequence, line watch
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cfgPrev_q <= 16'h0000;
      cfgWin_q <= '0;
      cfgExecOut <= '0;
      dapcSeq_q <= '0;
      ifFailCnt_q <= '0;
    end
    else
    begin
      cfgExecOut.valid <= cfgRun;
      if (cfgRun)
      begin
        cfgExecOut.frame <= rxIn.frame;
        cfgWin_q <= '0;
      end
      else if (isCfg)
      begin
        cfgPrev_q <= rxIn.frame;
        cfgWin_q <= CFG_WINDOW_TICKS;
      end
      else
        cfgWin_q <= tmr_dec(cfgWin_q, tick_q);
      if ((isArc && cmdByte == CMD_ENABLE_DAPC) || (isDapc && dapcSeq_q != '0))
        dapcSeq_q <= DAPC_SEQ_TICKS;
      else
        dapcSeq_q <= tmr_dec(dapcSeq_q, tick_q);
      if (busSync_q)
        ifFailCnt_q <= '0;
      else if (tick_q && ifFailCnt_q != IF_FAIL_TICKS)
        ifFailCnt_q <= ifFailCnt_q + dgch_tmr_t'(1);
    end
  end

  // saving: a change arriving with the request start keeps the pending flag
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      savePend_q <= 1'b0;
      saveBusy_q <= 1'b0;
      nvmSaveReq <= 1'b0;
      prevActual_q <= 8'h00;
      sysFail_q <= 1'b0;
    end
    else
    begin
      prevActual_q <= actual_q;
      nvmSaveReq <= saveStart;
      if (cfgRun || prevActual_q != actual_q)
        savePend_q <= 1'b1;
      else if (saveStart)
        savePend_q <= 1'b0;
      if (saveStart)
        saveBusy_q <= 1'b1;
      else if (nvmIn.done || nvmIn.fail)
        saveBusy_q <= 1'b0;
      if (saveFailEvt || ifFailEvt)
        sysFail_q <= 1'b1;
      else if (failClr)
        sysFail_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      actualLevel <= 8'h00;
      statusInfo <= 8'h00;
    end
    else
    begin
      actualLevel <= actual_q;
      statusInfo <= statusByte;
    end
  end

  // avalon slave: waitrequest drops one cycle after the request appears
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      shortAddr_q <= RST_SHORT_ADDR;
      groupMask_q <= RST_GROUP_MASK;
      minLevel_q <= RST_MIN_LEVEL;
      maxLevel_q <= RST_MAX_LEVEL;
      fadeCount_q <= RST_FADE_COUNT;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
      begin
        case (avs_address)
          REG_ADDR: avs_readdata <= {groupMask_q, 10'h000, shortAddr_q};
          REG_LEVEL: avs_readdata <= {8'h00, fadeCount_q, maxLevel_q, minLevel_q};
          REG_STATUS: avs_readdata <= {9'h000, savePend_q, blockTmr_q != '0, answerPend_q,
                                       dapcSeq_q != '0, cfgWin_q != '0, saveBusy_q, sysFail_q, target_q, statusByte};
          REG_FRAME: avs_readdata <= {8'h00, answerData_q, lastFrame_q};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
      if (avs_write && !avs_waitrequest)
      begin
        case (avs_address)
          REG_ADDR:
          begin
            shortAddr_q <= addrMerge[5:0];
            groupMask_q <= addrMerge[31:16];
          end
          REG_LEVEL:
          begin
            minLevel_q <= levelMerge[7:0];
            maxLevel_q <= levelMerge[15:8];
            fadeCount_q <= levelMerge[23:16];
          end
          default: fadeCount_q <= fadeCount_q;
        endcase
      end
    end
  end

endmodule

// file: bench/dgch_props.sv
`timescale 1ns/10ps
module dgch_props
  import dgch_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)(
  input wire logic mclk,
  input wire logic reset_n,
  input wire dgch_rx_s rxIn,
  input wire logic rxFlagClear,
  input wire logic busLine,
  input wire logic randomAddrBusy,
  input wire dgch_nvm_s nvmIn,
  input wire logic nvmSaveReq,
  input wire dgch_byte_s answerOut,
  input wire dgch_frame_s cfgExecOut,
  input wire dgch_frame_s specialOut,
  input wire logic [7:0] statusInfo
);
  int unsigned sinceClr;
  int unsigned lowCnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // both counters saturate so a long idle stretch cannot wrap
  always_ff @(posedge mclk)
  begin
    if (!reset_n || rxFlagClear) sinceClr <= 0;
    else if (sinceClr < 10 * TICK_CYCLES_P) sinceClr <= sinceClr + 1;
  end
  always_ff @(posedge mclk)
  begin
    if (!reset_n || busLine) lowCnt <= 0;
    else if (lowCnt < 600 * TICK_CYCLES_P) lowCnt <= lowCnt + 1;
  end
  sequence s_poll;
    rxIn.done && !rxFlagClear;
  endsequence
  sequence s_clear;
    rxFlagClear ##1 !rxFlagClear;
  endsequence
  poll_clear_a: assert property (s_poll |=> s_clear)
    else $error("receiver flags not cleared once after done");
  special_route_a: assert property (specialOut.valid |-> rxFlagClear && !$past(rxIn.error)
    && specialOut.frame == $past(rxIn.frame) && specialOut.frame[15]
    && specialOut.frame[15:13] != 3'b100 && specialOut.frame[15:9] != 7'h7f)
    else $error("special frame routed wrongly");
  cfg_repeat_a: assert property (cfgExecOut.valid |-> rxFlagClear && cfgExecOut.frame[8]
    && cfgExecOut.frame == $past(rxIn.frame) && cfgExecOut.frame[7:0] >= CMD_CFG_FIRST
    && cfgExecOut.frame[7:0] <= CMD_CFG_LAST)
    else $error("configuration executed without a matching frame");
  answer_delay_a: assert property (answerOut.valid |-> sinceClr + 3 >= 3 * TICK_CYCLES_P
    && sinceClr <= 4 * TICK_CYCLES_P + 3)
    else $error("answer sent outside its wait");
  save_gate_a: assert property (nvmSaveReq |-> !$past(randomAddrBusy))
    else $error("save started while addressing busy");
  save_fail_a: assert property (nvmIn.fail |-> ##[1:2] statusInfo[STS_FAIL_BIT])
    else $error("failed save did not set failure");
  line_fail_a: assert property (lowCnt >= 502 * TICK_CYCLES_P |-> statusInfo[STS_FAIL_BIT])
    else $error("low bus line did not set failure");
  reset_quiet_a: assert property ($rose(reset_n) |-> !answerOut.valid && !nvmSaveReq
    && statusInfo == 8'h00)
    else $error("outputs not quiet after reset");
endmodule
bind dgch_command_handler dgch_props #(.TICK_CYCLES_P(TICK_CYCLES_P)) props (.mclk(mclk), .reset_n(reset_n),
  .rxIn(rxIn), .rxFlagClear(rxFlagClear), .busLine(busLine), .randomAddrBusy(randomAddrBusy), .nvmIn(nvmIn),
  .nvmSaveReq(nvmSaveReq), .answerOut(answerOut), .cfgExecOut(cfgExecOut), .specialOut(specialOut),
  .statusInfo(statusInfo));

// file: bench/dgch_master_model.sv
`timescale 1ns/10ps
module dgch_master_model
  import dgch_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sendReq,
  input wire logic [15:0] sendFrame,
  input wire logic sendErr,
  input wire logic lineLow,
  input wire logic rxFlagClear,
  output dgch_rx_s rxIn,
  output logic busLine
);
  assign busLine = !lineLow;
  // a released frame toggles every cycle so stale data cannot pass for valid
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      rxIn <= '0;
    else if (rxIn.done && rxFlagClear)
    begin
      rxIn.done <= 1'b0;
      rxIn.error <= 1'b0;
      rxIn.frame <= ~rxIn.frame;
    end
    else if (!rxIn.done && sendReq)
    begin
      rxIn.done <= 1'b1;
      rxIn.error <= sendErr;
      rxIn.frame <= sendFrame;
    end
    else if (!rxIn.done)
      rxIn.frame <= ~rxIn.frame;
  end
endmodule

// file: bench/tb_dali_gear_command_handler.sv
`timescale 1ns/10ps
module tb_dali_gear_command_handler
  import dgch_pkg::*;
;
  localparam int unsigned TC = 20;
  logic mclk, reset_n, avs_read, avs_write, avs_waitrequest, rxFlagClear, busLine;
  logic randomAddrBusy, nvmSaveReq, sendReq, sendErr, lineLow, nvmFail;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] sendFrame;
  logic [7:0] actualLevel, statusInfo;
  dgch_rx_s rxIn;
  dgch_nvm_s nvmIn;
  dgch_byte_s answerOut;
  dgch_frame_s cfgExecOut, specialOut;
  int errorCnt = 0;
  int nChecks = 0;
  int specCnt = 0;
  int cfgCnt = 0;
  int ansCnt = 0;
  int saveCnt = 0;
  dgch_command_handler #(.TICK_CYCLES_P(TC)) dut (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxIn(rxIn), .rxFlagClear(rxFlagClear),
    .busLine(busLine), .randomAddrBusy(randomAddrBusy), .nvmIn(nvmIn), .nvmSaveReq(nvmSaveReq),
    .answerOut(answerOut), .cfgExecOut(cfgExecOut), .specialOut(specialOut), .actualLevel(actualLevel),
    .statusInfo(statusInfo));
  dgch_master_model master (.mclk(mclk), .reset_n(reset_n), .sendReq(sendReq), .sendFrame(sendFrame),
    .sendErr(sendErr), .lineLow(lineLow), .rxFlagClear(rxFlagClear), .rxIn(rxIn), .busLine(busLine));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // storage answers each save one cycle later
  always @(posedge mclk)
  begin
    nvmIn.done <= nvmSaveReq && !nvmFail;
    nvmIn.fail <= nvmSaveReq && nvmFail;
    if (nvmSaveReq) saveCnt <= saveCnt + 1;
    if (specialOut.valid === 1'b1) specCnt <= specCnt + 1;
    if (cfgExecOut.valid === 1'b1) cfgCnt <= cfgCnt + 1;
    if (answerOut.valid === 1'b1) ansCnt <= ansCnt + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic avx(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge mclk);
    // this wait ends when waitrequest drops; only the watchdog bounds it
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge mclk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic send(input logic [15:0] f, input logic e);
    @(posedge mclk);
    sendFrame <= f;
    sendErr <= e;
    sendReq <= 1'b1;
    @(posedge mclk);
    sendReq <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic tk(input int n);
    repeat (n * TC) @(posedge mclk);
  endtask
  task automatic t_regs();
    avx(0, REG_ADDR, 0);
    check(q, 32'h0000003f);
    avx(0, REG_LEVEL, 0);
    check(q, 32'h0000fe01);
    avx(0, REG_STATUS, 0);
    check(q, 32'h00000000);
    avx(1, REG_FRAME, 32'hffffffff);
    avx(0, REG_FRAME, 0);
    check(q, 32'h00000000);
    avx(0, 4'h2, 0);
    check(q, 32'h00000000);
  endtask
  task automatic t_level();
    avx(1, REG_ADDR, 32'h00040005);
    avx(1, REG_LEVEL, 32'h00008010);
    send(16'h0ac0, 0);
    check(actualLevel, 8'h80);
    check(statusInfo[STS_LAMP_ON_BIT], 1);
    send(16'h0a05, 0);
    check(actualLevel, 8'h10);
    send(16'h0c40, 0);
    check(actualLevel, 8'h10);
    send(16'hff05, 0);
    check(actualLevel, 8'h80);
    send(16'h0b06, 0);
    check(actualLevel, 8'h10);
    send(16'h8505, 0);
    check(actualLevel, 8'h80);
    send(16'h0b04, 0);
    check(actualLevel, 8'h7f);
    send(16'h0b03, 0);
    check(actualLevel, 8'h80);
    send(16'h0aff, 0);
    check(actualLevel, 8'h80);
    send(16'h0b09, 0);
    avx(0, REG_STATUS, 0);
    check(q[19], 1);
  endtask
  task automatic t_fade();
    avx(1, REG_LEVEL, 32'h00028010);
    send(16'h0a40, 0);
    tk(5);
    check(actualLevel, 8'h80);
    check(statusInfo[STS_FADE_BIT], 1);
    tk(25);
    check(actualLevel, 8'h40);
    check(statusInfo[STS_FADE_BIT], 0);
    send(16'h0b00, 0);
    check(actualLevel, 8'h00);
    send(16'h0b05, 0);
    check(actualLevel, 8'h00);
    send(16'h0a40, 0);
    check(actualLevel, 8'h40);
    check(statusInfo[STS_FADE_BIT], 0);
    avx(1, REG_LEVEL, 32'h00008010);
  endtask
  task automatic t_query();
    send({8'h0b, CMD_QRY_ACTUAL}, 0);
    for (int i = 0; i < 6 * TC && ansCnt == 0; i++) @(posedge mclk);
    check(ansCnt, 1);
    check(answerOut.data, 8'h40);
    avx(0, REG_STATUS, 0);
    check(q[21], 1);
    send(16'ha500, 0);
    check(specCnt, 0);
    tk(16);
    send(16'ha500, 1);
    check(specCnt, 0);
    send(16'ha500, 0);
    check(specCnt, 1);
    send({8'h0b, CMD_QRY_MAX}, 0);
    for (int i = 0; i < 6 * TC && ansCnt == 1; i++) @(posedge mclk);
    check(answerOut.data, 8'h80);
    tk(20);
    send({8'h0b, CMD_QRY_STATUS}, 0);
    for (int i = 0; i < 6 * TC && ansCnt == 2; i++) @(posedge mclk);
    check(ansCnt, 3);
    check(answerOut.data, 8'h04);
    tk(20);
  endtask
  task automatic t_cfg();
    send(16'h0b2a, 0);
    tk(110);
    send(16'h0b2a, 0);
    check(cfgCnt, 0);
    send(16'h0b2a, 0);
    check(cfgCnt, 1);
  endtask
  task automatic t_save();
    check(saveCnt, 0);
    randomAddrBusy <= 1'b0;
    for (int i = 0; i < 20 && saveCnt == 0; i++) @(posedge mclk);
    check(saveCnt, 1);
    repeat (4) @(posedge mclk);
    check(statusInfo[STS_FAIL_BIT], 1);
    nvmFail <= 1'b0;
    avx(1, REG_STATUS, 32'h00000100);
    repeat (3) @(posedge mclk);
    check(statusInfo[STS_FAIL_BIT], 0);
  endtask
  task automatic t_line();
    lineLow <= 1'b1;
    tk(490);
    check(statusInfo[STS_FAIL_BIT], 0);
    tk(15);
    check(statusInfo[STS_FAIL_BIT], 1);
    lineLow <= 1'b0;
  endtask
  initial
  begin
    repeat (40000) @(posedge mclk);
    errorCnt++;
    conclude();
  end
  initial
  begin
    reset_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    sendReq = 1'b0;
    sendFrame = 16'h0;
    sendErr = 1'b0;
    lineLow = 1'b0;
    randomAddrBusy = 1'b1;
    nvmFail = 1'b1;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_level();
    t_fade();
    t_query();
    t_cfg();
    t_save();
    t_line();
    conclude();
  end
endmodule
